/* hdl/strobe_defs.svh */
// Function
// - Detect enable set: internal sync pulse derived from sample strobe drives timing logic.
// - Detect enable clear: synchronised strobe level goes straight to timing logic, undelayed.
// - Three-bit delay field at bits 3:1, reset zero, ignored while detection off.
// - Detection on: pulse emitted exactly delay-field master clock periods after detected edge.
// - Polarity select at bit 4, reset zero, no effect while detection off.
// - Detection on, polarity zero: falling strobe edges generate the timing pulse.
// - Detection on, polarity one: rising strobe edges generate the timing pulse.
// - Power-disable field bits 3:0, reset zero, acts only while selective powerdown enabled.
// - While active, a one switches its cell off, a zero leaves it on.
// - Bit 0 red channel, bit 1 green, bit 2 blue, bit 3 converter.
`ifndef STROBE_DEFS_SVH
`define STROBE_DEFS_SVH

// ==================================================================
// Register map (byte addresses)
`define ADDR_W            8
`define CFG_OFFSET        8'h00
`define PWR_OFFSET        8'h04
`define CTRL_OFFSET       8'h08
`define STAT_OFFSET       8'h0c

// ==================================================================
// Field positions
`define CFG_DET_BIT       0
`define CFG_DELAY_LSB     1
`define CFG_DELAY_MSB     3
`define CFG_POL_BIT       4
`define PWR_FIELD_MSB     3
`define CTRL_SELECTIVE_POWERDOWN_ENABLE_BIT    0
`define STAT_LEVEL_BIT    0
`define STAT_PULSE_BIT    1
`define STAT_COUNT_LSB    8
`define STAT_COUNT_MSB    15

// ==================================================================
// Reset values and sizes
`define CFG_DELAY_RESET   3'h0
`define PWR_RESET         4'h0
`define DELAY_STAGES      7
`define CELL_COUNT        4

`endif

/* hdl/strobe_pkg.sv */
package strobe_pkg;
   // Register selected by an APB address
   typedef enum logic [2:0] {
      SEL_CFG,
      SEL_PWR,
      SEL_CTRL,
      SEL_STAT,
      SEL_NONE
   } reg_sel_type;

   // Delay field value
   typedef logic [2:0] delay_type;
endpackage

/* hdl/strobe_timing_if.sv */
`timescale 1ns/1ps
// Link between register side and edge/delay engine
interface strobe_timing_if;
   logic                  syncLevel;    // Synchronised strobe level
   logic                  detectEnable; // Edge detection on
   logic                  risingSelect; // 1 rising, 0 falling
   strobe_pkg::delay_type delaySel;     // Delay in master clocks
   logic                  tapPulse;     // Delayed pulse, combinational
   logic                  edgeHit;      // Selected edge seen this cycle

   modport ctrl (output syncLevel, output detectEnable, output risingSelect, output delaySel,
                 input tapPulse, input edgeHit);
   modport det  (input syncLevel, input detectEnable, input risingSelect, input delaySel,
                 output tapPulse, output edgeHit);
endinterface

/* hdl/strobe_edge_delay.sv */
`timescale 1ns/1ps
`include "strobe_defs.svh"
module strobe_edge_delay
   import strobe_pkg::*;
(
   input  wire logic    ref_clk, // Master clock
   input  wire logic    rst_n,   // Async reset, active low
   strobe_timing_if.det tim      // Configuration in, pulse out
);
   logic                     strobeLast_reg;
   logic [`DELAY_STAGES-1:0] delayLine_reg;
   logic                     edgeNow;

   // ==================================================================
   // Edge detection
   // Previous synchronised level
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeLast_reg <= 1'b0;
      end else begin
         strobeLast_reg <= tim.syncLevel;
      end
   end

   // Chosen polarity edge
   assign edgeNow = tim.risingSelect ? (tim.syncLevel & ~strobeLast_reg)
                                     : (~tim.syncLevel & strobeLast_reg);
   assign tim.edgeHit = edgeNow & tim.detectEnable;

   // ==================================================================
   // Delay line, one stage per master clock
   generate
      for (genvar i = 0; i < `DELAY_STAGES; i++) begin : gStage
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               delayLine_reg[i] <= 1'b0;
            end else if (!tim.detectEnable) begin
               delayLine_reg[i] <= 1'b0;
            end else if (i == 0) begin
               delayLine_reg[i] <= edgeNow;
            end else begin
               delayLine_reg[i] <= delayLine_reg[(i == 0) ? 0 : i - 1];
            end
         end
      end
   endgenerate

   // Tap selected by delay field
   assign tim.tapPulse = (tim.delaySel == 3'h0) ? tim.edgeHit
                                                : delayLine_reg[3'(tim.delaySel - 3'h1)];

   // ==================================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_fall_edge_seen: assert property (tim.detectEnable && !tim.risingSelect && $fell(tim.syncLevel)
                                      |-> tim.edgeHit) else $error("falling edge missed");
   a_rise_edge_seen: assert property (tim.detectEnable && tim.risingSelect && $rose(tim.syncLevel)
                                      |-> tim.edgeHit) else $error("rising edge missed");
   a_wrong_edge_ignored: assert property (tim.detectEnable && $changed(tim.syncLevel)
                                          && (tim.syncLevel != tim.risingSelect)
                                          |-> !tim.edgeHit) else $error("wrong edge used");
endmodule

/* hdl/strobe_edge_detect_power_cfg.sv */
`timescale 1ns/1ps
`include "strobe_defs.svh"
module strobe_edge_detect_power_cfg
   import strobe_pkg::*;
(
   input  wire logic                   ref_clk,          // Master clock, 20 MHz
   input  wire logic                   rst_n,            // Async reset, active low
   // APB slave
   input  wire logic [`ADDR_W-1:0]     paddr,            // Byte address
   input  wire logic                   psel,             // Slave select
   input  wire logic                   penable,          // Access phase
   input  wire logic                   pwrite,           // 1 write, 0 read
   input  wire logic [31:0]            pwdata,           // Write data
   output      logic [31:0]            prdata,           // Read data
   output      logic                   pready,           // Transfer done
   output      logic                   pslverr,          // Unmapped address
   // Strobe and timing
   input  wire logic                   sample_strobe_in, // External sample strobe pin
   output      logic                   timingPulse,      // To timing control
   // Power control
   output      logic [`CELL_COUNT-1:0] blockPowerOff     // 0 red, 1 green, 2 blue, 3 converter
);

   // ==================================================================
   // Declarations
   logic                   strobeMeta_reg;
   logic                   strobeSync_reg;
   logic                   cfgDetect_reg;
   delay_type              cfgDelay_reg;
   logic                   cfgPolarity_reg;
   logic [`CELL_COUNT-1:0] pwrDisable_reg;
   logic                   pdEnable_reg;
   logic [7:0]             pulseCount_reg;
   logic [7:0]             pulseCount_next;
   logic                   accessStart;
   logic                   accessDone;
   logic                   writeDone;
   reg_sel_type            startSel;
   reg_sel_type            doneSel;
   logic [31:0]            readValue;

   strobe_timing_if tim ();

   // ==================================================================
   // Address decode
   // Map a byte address to a register
   function automatic reg_sel_type regSelect(input logic [`ADDR_W-1:0] addr);
      reg_sel_type sel;
      sel = SEL_NONE;
      unique case (addr)
         `CFG_OFFSET:  sel = SEL_CFG;
         `PWR_OFFSET:  sel = SEL_PWR;
         `CTRL_OFFSET: sel = SEL_CTRL;
         `STAT_OFFSET: sel = SEL_STAT;
         default:      sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   // ==================================================================
   // Strobe pin synchroniser
   // Two flops before any logic
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeMeta_reg <= 1'b0;
         strobeSync_reg <= 1'b0;
      end else begin
         strobeMeta_reg <= sample_strobe_in;
         strobeSync_reg <= strobeMeta_reg;
      end
   end

   // ==================================================================
   // APB handshake
   // One wait state: setup, access, access with pready
   assign accessStart = psel & penable & ~pready;
   assign accessDone  = psel & penable & pready;
   assign writeDone   = accessDone & pwrite;
   assign startSel    = regSelect(paddr);
   assign doneSel     = regSelect(paddr);

   // Ready pulse one cycle after access begins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= accessStart;
      end
   end

   // Error flagged with ready for unmapped addresses
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= accessStart && (startSel == SEL_NONE);
      end
   end

   // ==================================================================
   // Read path
   // Read mux, reserved bits as zero
   always_comb begin
      readValue = 32'h0000_0000;
      unique case (startSel)
         SEL_CFG: begin
            readValue[`CFG_DET_BIT]                   = cfgDetect_reg;
            readValue[`CFG_DELAY_MSB:`CFG_DELAY_LSB] = cfgDelay_reg;
            readValue[`CFG_POL_BIT]                   = cfgPolarity_reg;
         end
         SEL_PWR: begin
            readValue[`PWR_FIELD_MSB:0] = pwrDisable_reg;
         end
         SEL_CTRL: begin
            readValue[`CTRL_SELECTIVE_POWERDOWN_ENABLE_BIT] = pdEnable_reg;
         end
         SEL_STAT: begin
            readValue[`STAT_LEVEL_BIT]                  = strobeSync_reg;
            readValue[`STAT_PULSE_BIT]                  = timingPulse;
            readValue[`STAT_COUNT_MSB:`STAT_COUNT_LSB] = pulseCount_reg;
         end
         SEL_NONE: begin
            readValue = 32'h0000_0000;
         end
      endcase
   end

   // Read data captured for the ready cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (accessStart && !pwrite) begin
         prdata <= readValue;
      end else if (accessDone) begin
         prdata <= 32'h0000_0000;
      end
   end

   // ==================================================================
   // Strobe configuration register
   // Reserved bits 7:5 are not stored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfgDetect_reg   <= 1'b0;
         cfgDelay_reg    <= `CFG_DELAY_RESET;
         cfgPolarity_reg <= 1'b0;
      end else if (writeDone && doneSel == SEL_CFG) begin
         cfgDetect_reg   <= pwdata[`CFG_DET_BIT];
         cfgDelay_reg    <= pwdata[`CFG_DELAY_MSB:`CFG_DELAY_LSB];
         cfgPolarity_reg <= pwdata[`CFG_POL_BIT];
      end
   end

   // ==================================================================
   // Power disable and control registers
   // Per-cell disable field
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwrDisable_reg <= `PWR_RESET;
      end else if (writeDone && doneSel == SEL_PWR) begin
         pwrDisable_reg <= pwdata[`PWR_FIELD_MSB:0];
      end
   end

   // Selective powerdown enable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pdEnable_reg <= 1'b0;
      end else if (writeDone && doneSel == SEL_CTRL) begin
         pdEnable_reg <= pwdata[`CTRL_SELECTIVE_POWERDOWN_ENABLE_BIT];
      end
   end

   // ==================================================================
   // Edge and delay engine
   // Drive engine configuration
   assign tim.syncLevel    = strobeSync_reg;
   assign tim.detectEnable = cfgDetect_reg;
   assign tim.risingSelect = cfgPolarity_reg;
   assign tim.delaySel     = cfgDelay_reg;

   strobe_edge_delay engine (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tim     (tim.det)
   );

   // ==================================================================
   // Timing control output
   // Detect mode takes delayed pulse, else synchronised level
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timingPulse <= 1'b0;
      end else if (cfgDetect_reg) begin
         timingPulse <= tim.tapPulse;
      end else begin
         timingPulse <= strobeSync_reg;
      end
   end

   // Count generated pulses, wraps
   assign pulseCount_next = pulseCount_reg + 8'h01;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulseCount_reg <= 8'h00;
      end else if (cfgDetect_reg && tim.tapPulse) begin
         pulseCount_reg <= pulseCount_next;
      end
   end

   // ==================================================================
   // Cell power outputs
   // One gate per cell, field only while enabled
   generate
      for (genvar c = 0; c < `CELL_COUNT; c++) begin : gCell
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               blockPowerOff[c] <= 1'b0;
            end else begin
               blockPowerOff[c] <= pdEnable_reg & pwrDisable_reg[c];
            end
         end
      end
   endgenerate

   // ==================================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Synchroniser depth and pass-through
   a_sync_two_stage: assert property ($past(rst_n, 2) |-> strobeSync_reg == $past(sample_strobe_in, 2))
      else $error("strobe synchroniser depth wrong");

   a_pass_through_level: assert property (!cfgDetect_reg |=> timingPulse == $past(strobeSync_reg))
      else $error("strobe level not passed through");

   // ==================================================================
   // Delay tap checks
   // Undelayed pulse comes at once and only after an edge
   a_delay_zero_pulse: assert property (cfgDetect_reg && cfgDelay_reg == 3'h0 && tim.edgeHit
                                        |=> timingPulse)
      else $error("undelayed pulse missing");

   a_delay_zero_quiet: assert property (cfgDetect_reg && cfgDelay_reg == 3'h0 && !tim.edgeHit
                                        |=> !timingPulse)
      else $error("undelayed pulse without edge");

   // Delayed pulses, configuration held while the edge travels
   a_delay_one_pulse: assert property (cfgDetect_reg && cfgDelay_reg == 3'h1 && tim.edgeHit
                                       ##1 (cfgDetect_reg && cfgDelay_reg == 3'h1)
                                       |=> timingPulse)
      else $error("pulse not one clock late");

   a_delay_three_pulse: assert property (cfgDetect_reg && cfgDelay_reg == 3'h3 && tim.edgeHit
                                         ##1 (cfgDetect_reg && cfgDelay_reg == 3'h3)[*3]
                                         |=> timingPulse)
      else $error("pulse not three clocks late");

   a_delay_seven_pulse: assert property (cfgDetect_reg && cfgDelay_reg == 3'h7 && tim.edgeHit
                                         ##1 (cfgDetect_reg && cfgDelay_reg == 3'h7)[*7]
                                         |=> timingPulse)
      else $error("pulse not seven clocks late");

   a_delay_no_early: assert property (cfgDetect_reg && cfgDelay_reg == 3'h2 && tim.edgeHit
                                      && !$past(tim.edgeHit, 2) && !$past(tim.edgeHit)
                                      ##1 (cfgDetect_reg && cfgDelay_reg == 3'h2)
                                      |=> !timingPulse)
      else $error("pulse came early");

   // Pulses stay one clock wide
   a_pulse_single_clock: assert property (cfgDetect_reg && $past(cfgDetect_reg)
                                          && $stable(cfgDelay_reg) && $stable(cfgPolarity_reg)
                                          && timingPulse |=> !timingPulse)
      else $error("pulse wider than one clock");

   // Pulse counter steps once per generated pulse
   a_pulse_count_step: assert property (cfgDetect_reg && tim.tapPulse
                                        |=> pulseCount_reg == $past(pulseCount_reg) + 8'h01)
      else $error("pulse count did not step");

   a_pulse_count_hold: assert property (!(cfgDetect_reg && tim.tapPulse) |=> $stable(pulseCount_reg))
      else $error("pulse count moved without pulse");

   // ==================================================================
   // Register write checks
   a_cfg_write_lands: assert property (writeDone && doneSel == SEL_CFG
                                       |=> cfgDetect_reg == $past(pwdata[`CFG_DET_BIT])
                                           && cfgDelay_reg == $past(pwdata[`CFG_DELAY_MSB:`CFG_DELAY_LSB])
                                           && cfgPolarity_reg == $past(pwdata[`CFG_POL_BIT]))
      else $error("config write lost");

   a_pwr_write_lands: assert property (writeDone && doneSel == SEL_PWR
                                       |=> pwrDisable_reg == $past(pwdata[`PWR_FIELD_MSB:0]))
      else $error("power field write lost");

   a_ctrl_write_lands: assert property (writeDone && doneSel == SEL_CTRL
                                        |=> pdEnable_reg == $past(pwdata[`CTRL_SELECTIVE_POWERDOWN_ENABLE_BIT]))
      else $error("powerdown enable write lost");

   a_stray_write_ignored: assert property (writeDone && (doneSel == SEL_NONE || doneSel == SEL_STAT)
                                           |=> $stable(cfgDetect_reg) && $stable(cfgDelay_reg)
                                               && $stable(cfgPolarity_reg) && $stable(pwrDisable_reg)
                                               && $stable(pdEnable_reg))
      else $error("stray write changed a register");

   // ==================================================================
   // Cell power checks
   a_power_gated_off: assert property (!pdEnable_reg |=> blockPowerOff == 4'h0)
      else $error("cell off without powerdown enable");

   a_power_field_map: assert property (pdEnable_reg |=> blockPowerOff == $past(pwrDisable_reg))
      else $error("cell power not following field");

   a_power_hold_steady: assert property ($stable(pdEnable_reg) && $stable(pwrDisable_reg)
                                         |=> $stable(blockPowerOff))
      else $error("cell power moved on its own");

   // ==================================================================
   // Bus checks
   a_apb_ready_wait: assert property (accessStart |=> pready ##1 !pready)
      else $error("ready not one cycle after access");

   a_ready_after_access: assert property (pready |-> $past(psel && penable))
      else $error("ready without access phase");

   a_apb_unmapped_err: assert property (accessStart && startSel == SEL_NONE |=> pslverr && pready)
      else $error("unmapped address not flagged");

   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");

   a_read_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside ready cycle");

   // ==================================================================
   // Scenario cover points
   c_pass_through: cover property (!cfgDetect_reg && $rose(timingPulse));
   c_rise_delay_seven: cover property (cfgDetect_reg && cfgPolarity_reg && cfgDelay_reg == 3'h7
                                       && timingPulse);
   c_fall_delay_zero: cover property (cfgDetect_reg && !cfgPolarity_reg && cfgDelay_reg == 3'h0
                                      && timingPulse);
   c_power_cells_off: cover property (pdEnable_reg && blockPowerOff == 4'hf);
   c_status_read: cover property (accessDone && !pwrite && doneSel == SEL_STAT);
endmodule

/* tb/strobe_source_model.sv */
`timescale 1ns/1ps
// ==================================================================
// Scan timing controller stand-in: one strobe of a chosen length
module strobe_source_model (
   input  wire logic       ref_clk,   // Master clock
   input  wire logic       rst_n,     // Async reset, active low
   input  wire logic       go,        // One-cycle request for a strobe
   input  wire logic [3:0] highLen,   // Strobe high time in clocks, 2 or more
   output      logic       strobeOut  // Sample strobe pin
);
   logic [3:0] countReg;

   // Raise on request, drop after highLen clocks; busy requests ignored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeOut <= 1'b0;
         countReg  <= 4'h0;
      end else if (go && countReg == 4'h0) begin
         strobeOut <= 1'b1;
         countReg  <= highLen;
      end else if (countReg == 4'h1) begin
         strobeOut <= 1'b0;
         countReg  <= 4'h0;
      end else if (countReg != 4'h0) begin
         countReg  <= countReg - 4'h1;
      end
   end
endmodule

/* tb/strobe_edge_detect_power_cfg_tb_top.sv */
`timescale 1ns/1ps
`include "strobe_defs.svh"
module strobe_edge_detect_power_cfg_tb_top;
   import strobe_pkg::*;

   logic        ref_clk;
   logic        rst_n;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        strobe;
   logic        timingPulse;
   logic [3:0]  blockPowerOff;
   logic        go;
   logic [3:0]  highLen;
   logic [31:0] cyc;
   logic [31:0] riseCyc;
   logic        prevPulse;
   logic [63:0] busQ[$];
   logic [63:0] pulseQ[$];
   int          miscompares;
   int          totalChecks;
   int          seed;

   // ==================================================================
   // Design and strobe source
   strobe_edge_detect_power_cfg uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_strobe_in(strobe), .timingPulse(timingPulse), .blockPowerOff(blockPowerOff));

   strobe_source_model src (
      .ref_clk(ref_clk), .rst_n(rst_n), .go(go), .highLen(highLen), .strobeOut(strobe));

   // Clock and cycle count
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 32'h1;

   // ==================================================================
   // Shared helpers
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      if (miscompares == 0 && totalChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic hang();
      miscompares++;
      conclude();
   endtask

   // APB transfer; expected error flag and read data noted for the monitor
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      input logic [31:0] ed, input logic ee);
      int n;
      busQ.push_back({31'h0, ee, ed});
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang();
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // One strobe with the expected pulse start and width noted
   task automatic shot(input logic det, input logic pol, input logic [2:0] d, input logic [3:0] h);
      logic [31:0] a;
      int          n;
      apb(`CFG_OFFSET, 1'b1, {27'h0, pol, d, det}, 32'h0, 1'b0);
      @(posedge ref_clk);
      go      <= 1'b1;
      highLen <= h;
      a = cyc + 32'h1;
      if (!det) pulseQ.push_back({a + 32'h4, 28'h0, h});
      else if (pol) pulseQ.push_back({a + 32'h4 + d, 32'h1});
      else pulseQ.push_back({a + 32'h4 + h + d, 32'h1});
      @(posedge ref_clk);
      go <= 1'b0;
      n = 0;
      while ((pulseQ.size() != 0 || strobe !== 1'b0) && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 60) hang();
      repeat (12) @(posedge ref_clk);
   endtask

   // ==================================================================
   // Monitors: bus answers at the pready edge, pulses at their fall
   always @(posedge ref_clk) begin
      if (rst_n && psel && penable && pready === 1'b1) begin
         if (busQ.size() == 0) check({31'h0, pslverr, prdata}, '1);
         else check({31'h0, pslverr, prdata}, busQ.pop_front());
      end
   end

   always @(negedge ref_clk) begin
      if (rst_n) begin
         if (timingPulse === 1'b1 && !prevPulse) riseCyc = cyc;
         if (timingPulse !== 1'b1 && prevPulse) begin
            if (pulseQ.size() == 0) check({riseCyc, cyc - riseCyc}, '1);
            else check({riseCyc, cyc - riseCyc}, pulseQ.pop_front());
         end
         prevPulse = (timingPulse === 1'b1);
      end
   end

   // ==================================================================
   // Main sequence
   initial begin
      logic [3:0] f;
      ref_clk = 1'b0; rst_n = 1'b0; cyc = 32'h0; prevPulse = 1'b0; riseCyc = 32'h0;
      paddr = 8'h00; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; pwdata = 32'h0;
      go = 1'b0; highLen = 4'h2; miscompares = 0; totalChecks = 0; seed = 32'hb93f;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      // Reset values and unmapped places
      apb(`CFG_OFFSET, 1'b0, 32'h0, 32'h0, 1'b0);
      apb(`PWR_OFFSET, 1'b0, 32'h0, 32'h0, 1'b0);
      apb(`CTRL_OFFSET, 1'b0, 32'h0, 32'h0, 1'b0);
      apb(8'h10, 1'b0, 32'h0, 32'h0, 1'b1);
      apb(8'h14, 1'b1, 32'hffff_ffff, 32'h0, 1'b1);
      apb(`CFG_OFFSET, 1'b1, 32'h0000_001b, 32'h0, 1'b0);
      apb(`CFG_OFFSET, 1'b0, 32'h0, 32'h0000_001b, 1'b0);
      // Detection at every delay, both polarities
      for (int i = 0; i < 8; i++) begin
         shot(1'b1, i[0], i[2:0], 4'(2 + ($random(seed) & 7)));
      end
      // Pass-through ignores delay and polarity
      for (int i = 0; i < 3; i++) begin
         shot(1'b0, i[0], 3'($random(seed)), 4'(2 + ($random(seed) & 7)));
      end
      // Power field gated by selective powerdown, one bit per cell
      for (int i = 0; i < 6; i++) begin
         f = (i < 4) ? 4'(1 << i) : 4'($random(seed));
         apb(`CTRL_OFFSET, 1'b1, 32'h0, 32'h0, 1'b0);
         apb(`PWR_OFFSET, 1'b1, {28'h0, f}, 32'h0, 1'b0);
         repeat (3) @(posedge ref_clk);
         check({60'h0, blockPowerOff}, 64'h0);
         apb(`CTRL_OFFSET, 1'b1, 32'h1, 32'h0, 1'b0);
         repeat (3) @(posedge ref_clk);
         check({60'h0, blockPowerOff}, {60'h0, f});
         apb(`PWR_OFFSET, 1'b0, 32'h0, {28'h0, f}, 1'b0);
      end
      // Status: eight detect-mode pulses counted, strobe and pulse idle
      apb(`STAT_OFFSET, 1'b0, 32'h0, 32'h0000_0800, 1'b0);
      repeat (4) @(posedge ref_clk);
      check({busQ.size(), pulseQ.size()}, 64'h0);
      conclude();
   end
endmodule
